// >>> cpu_exec_pkg.sv
// shared constants, opcodes, states and core state layout of the execution core
package cpu_exec_pkg;
	// opcodes handled by the core
	localparam logic [7:0]  OP_SOFTWARE_TRAP = 8'h83;
	localparam logic [7:0]  OP_ACC_TO_FLAGS  = 8'h84;
	localparam logic [7:0]  OP_FLAGS_TO_ACC  = 8'h85;
	localparam logic [7:0]  OP_ACC_TO_IDX    = 8'h97;
	localparam logic [7:0]  OP_IDX_TO_ACC    = 8'h9F;
	localparam logic [7:0]  OP_SP_TO_IDX     = 8'h95;
	localparam logic [7:0]  OP_IDX_TO_SP     = 8'h94;
	localparam logic [7:0]  OP_TEST_DIR      = 8'h3D;
	localparam logic [7:0]  OP_TEST_ACC      = 8'h4D;
	localparam logic [7:0]  OP_TEST_IDX      = 8'h5D;
	localparam logic [7:0]  OP_WAIT          = 8'h8F;
	localparam logic [7:0]  OP_STOP          = 8'h8E;
	localparam logic [7:0]  OP_ACC_STORE     = 8'hB7;
	localparam logic [7:0]  OP_IDX_STORE     = 8'hBF;
	localparam logic [7:0]  OP_PAIR_STORE    = 8'h35;

	// addresses and reset values
	localparam logic [15:0] RESET_PC    = 16'hF000;
	localparam logic [15:0] RESET_SP    = 16'h00FF;
	localparam logic [15:0] TRAP_VEC_HI = 16'hFFFC;
	localparam logic [15:0] TRAP_VEC_LO = 16'hFFFD;
	localparam logic [15:0] WORD_ONE    = 16'h0001;
	localparam logic [7:0]  DIRECT_PAGE = 8'h00;
	localparam logic [7:0]  FLAGS_RESET = 8'h68;
	localparam logic [7:0]  FLAGS_ONES  = 8'h60;

	// flag positions inside the condition code register
	localparam int FLG_V = 7;
	localparam int FLG_H = 4;
	localparam int FLG_I = 3;
	localparam int FLG_N = 2;
	localparam int FLG_Z = 1;
	localparam int FLG_C = 0;
	localparam int MSB_BYTE = 7;
	localparam int MSB_WORD = 15;

	// execution steps; step 0 is the opcode fetch cycle
	localparam logic [3:0] STEP_ONE        = 4'h1;
	localparam logic [3:0] STEP_TWO        = 4'h2;
	localparam logic [3:0] STEP_THREE      = 4'h3;
	localparam logic [3:0] TRAP_PUSH_PCH   = 4'h1;
	localparam logic [3:0] TRAP_PUSH_IDX   = 4'h2;
	localparam logic [3:0] TRAP_PUSH_ACC   = 4'h3;
	localparam logic [3:0] TRAP_PUSH_FLAGS = 4'h4;
	localparam logic [3:0] TRAP_VEC_HI_ST  = 4'h5;
	localparam logic [3:0] TRAP_VEC_LO_ST  = 4'h6;
	localparam logic [3:0] TRAP_LOAD_ST    = 4'h7;
	localparam int         CYC_TRAP        = 11;
	localparam logic [3:0] TRAP_LAST       = 4'(CYC_TRAP - 1);

	typedef enum logic [3:0] {
		ST_FETCH = 4'h1,
		ST_EXEC  = 4'h2,
		ST_WAIT  = 4'h4,
		ST_STOP  = 4'h8
	} exec_state_e;

	typedef struct packed {
		exec_state_e st;
		logic [3:0]  step;
		logic [7:0]  op;
		logic [7:0]  a;
		logic [7:0]  x;
		logic [7:0]  h;
		logic [15:0] sp;
		logic [15:0] pc;
		logic [7:0]  cc;
		logic [15:0] ea;
		logic [15:0] baddr;
		logic [7:0]  bwdata;
		logic        bwe;
		logic        bre;
	} core_s;

	localparam core_s CORE_RESET = '{st: ST_FETCH, step: '0, op: '0, a: '0, x: '0, h: '0,
		sp: RESET_SP, pc: RESET_PC, cc: FLAGS_RESET, ea: '0, baddr: RESET_PC,
		bwdata: '0, bwe: 1'b0, bre: 1'b1};
endpackage : cpu_exec_pkg

// >>> flag_if.sv
// carrier between the core and its flag calculator
`timescale 1ns/10ps
interface flag_if;
	logic [15:0] value;
	logic        wide;
	logic [7:0]  flags_in;
	logic [7:0]  flags_out;
	modport calc (input value, input wide, input flags_in, output flags_out);
	modport user (output value, output wide, output flags_in, input flags_out);
endinterface : flag_if

// >>> word_step.sv
// sixteen-bit increment or decrement by one
`timescale 1ns/10ps
module word_step
	import cpu_exec_pkg::*;
(
	input  wire logic [15:0] value,
	input  wire logic        down,
	output logic [15:0]      result
);
	// a subtracter and an adder, down selects between them
	assign result = down ? (value - WORD_ONE) : (value + WORD_ONE);
endmodule : word_step

// >>> flag_calc.sv
// test and store flag update: clears overflow, sets negative and zero
`timescale 1ns/10ps
module flag_calc
	import cpu_exec_pkg::*;
(
	flag_if.calc f
);
	// carry, half carry and mask pass through untouched
	always_comb begin
		f.flags_out        = f.flags_in; // RULE12
		f.flags_out[FLG_V] = 1'b0;
		f.flags_out[FLG_N] = f.wide ? f.value[MSB_WORD] : f.value[MSB_BYTE];
		f.flags_out[FLG_Z] = f.wide ? (f.value == 16'h0000) : (f.value[7:0] == 8'h00);
	end
endmodule : flag_calc

// >>> cpu_exec_core.sv
// execution core for the store, transfer, test, trap, wait and stop instructions
// Operation
// RULE1 - trap 83 takes 11 cycles, pushes state, sets mask, loads vector
// RULE2 - 84 copies accumulator to flags in one cycle; 85 copies flags back
// RULE3 - 97 copies accumulator to index low in one cycle, flags kept
// RULE4 - 9F copies index low to accumulator in one cycle, flags kept
// RULE5 - 95 loads index pair with sp plus one; 94 sp with pair minus one
// RULE6 - tests clear overflow, set negative and zero, keep carry and half carry
// RULE7 - wait 8F clears mask, halts after three cycles until interrupt
// RULE8 - stop clears mask and ceases instruction processing
// RULE9 - index low store writes low index byte, updates flags
// RULE10 - accumulator store writes accumulator byte, updates flags
// RULE11 - pair store writes high byte then low byte at address plus one
// RULE12 - flags an instruction does not name keep their value
`timescale 1ns/10ps
module cpu_exec_core
	import cpu_exec_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic        wake_req,
	output logic [15:0]      mem_addr,
	output logic [7:0]       mem_wdata,
	output logic             mem_we,
	output logic             mem_re,
	output logic             op_fetch,
	output logic             wait_halt,
	output logic             stop_halt,
	output logic [7:0]       acc,
	output logic [7:0]       index_hi,
	output logic [7:0]       index_lo,
	output logic [15:0]      stack_ptr,
	output logic [15:0]      prog_cnt,
	output logic [7:0]       condition_code_reg
);
	core_s       q;
	core_s       d;
	logic [7:0]  opx;
	logic [15:0] pc_inc;
	logic [15:0] sp_dec;
	logic [15:0] sp_inc;
	logic [15:0] hx_dec;
	logic [15:0] ea_inc;

	flag_if fl ();

	// address arithmetic
	word_step u_pc_inc (.value(q.pc), .down(1'b0), .result(pc_inc));
	word_step u_sp_dec (.value(q.sp), .down(1'b1), .result(sp_dec));
	word_step u_sp_inc (.value(q.sp), .down(1'b0), .result(sp_inc));
	word_step u_hx_dec (.value({q.h, q.x}), .down(1'b1), .result(hx_dec));
	word_step u_ea_inc (.value(q.ea), .down(1'b0), .result(ea_inc));

	flag_calc u_flags (.f(fl.calc));

	// opcode in effect this cycle: the bus byte during fetch, the latched one after
	assign opx = (q.st == ST_FETCH) ? mem_rdata : q.op;

	// operand that the flag calculator sees
	always_comb begin
		fl.flags_in = q.cc;
		fl.wide     = 1'b0;
		fl.value    = {DIRECT_PAGE, q.x};
		case (opx)
			OP_TEST_ACC, OP_ACC_STORE: fl.value = {DIRECT_PAGE, q.a};
			OP_TEST_DIR:               fl.value = {DIRECT_PAGE, mem_rdata};
			OP_PAIR_STORE: begin
				fl.value = {q.h, q.x};
				fl.wide  = 1'b1;
			end
			default:                   fl.value = {DIRECT_PAGE, q.x};
		endcase
	end

	// next state; every cycle also schedules the bus access of the next cycle
	always_comb begin
		d      = q;
		d.bwe  = 1'b0;
		d.bre  = 1'b0;
		d.step = q.step + STEP_ONE;
		case (q.st)
			ST_FETCH: begin
				d.op    = mem_rdata;
				d.pc    = pc_inc;
				d.st    = ST_EXEC;
				d.step  = STEP_ONE;
				d.baddr = pc_inc;
				d.bre   = 1'b1; // next opcode or operand byte
				case (mem_rdata)
					OP_ACC_TO_FLAGS: begin
						d.cc = q.a | FLAGS_ONES; // RULE2
						d.st = ST_FETCH;
					end
					OP_FLAGS_TO_ACC: begin
						d.a  = q.cc; // RULE2
						d.st = ST_FETCH;
					end
					OP_ACC_TO_IDX: begin
						d.x  = q.a; // RULE3
						d.st = ST_FETCH;
					end
					OP_IDX_TO_ACC: begin
						d.a  = q.x; // RULE4
						d.st = ST_FETCH;
					end
					OP_TEST_ACC, OP_TEST_IDX: begin
						d.cc = fl.flags_out; // RULE6
						d.st = ST_FETCH;
					end
					OP_SOFTWARE_TRAP: begin
						d.bre    = 1'b0;
						d.bwe    = 1'b1; // RULE1
						d.baddr  = q.sp;
						d.bwdata = pc_inc[7:0];
						d.sp     = sp_dec;
					end
					OP_STOP: begin
						d.cc[FLG_I] = 1'b0; // RULE8
						d.st        = ST_STOP;
						d.bre       = 1'b0;
					end
					OP_WAIT, OP_SP_TO_IDX, OP_IDX_TO_SP: d.bre = 1'b0;
					OP_TEST_DIR, OP_ACC_STORE, OP_IDX_STORE, OP_PAIR_STORE: d.st = ST_EXEC;
					default: d.st = ST_FETCH; // unknown opcodes pass as one-cycle no-ops
				endcase
			end
			ST_EXEC: begin
				case (q.op)
					OP_SOFTWARE_TRAP: begin
						case (q.step)
							TRAP_PUSH_PCH, TRAP_PUSH_IDX, TRAP_PUSH_ACC, TRAP_PUSH_FLAGS: begin
								d.bwe   = 1'b1; // RULE1
								d.baddr = q.sp;
								d.sp    = sp_dec;
								case (q.step)
									TRAP_PUSH_PCH: d.bwdata = q.pc[15:8];
									TRAP_PUSH_IDX: d.bwdata = q.x;
									TRAP_PUSH_ACC: d.bwdata = q.a;
									default:       d.bwdata = q.cc;
								endcase
							end
							TRAP_VEC_HI_ST: begin
								d.cc[FLG_I] = 1'b1; // RULE1
								d.bre       = 1'b1;
								d.baddr     = TRAP_VEC_HI;
							end
							TRAP_VEC_LO_ST: begin
								d.pc[15:8] = mem_rdata; // RULE1
								d.bre      = 1'b1;
								d.baddr    = TRAP_VEC_LO;
							end
							TRAP_LOAD_ST: d.pc[7:0] = mem_rdata;
							TRAP_LAST: begin
								d.st    = ST_FETCH; // RULE1
								d.bre   = 1'b1;
								d.baddr = q.pc;
							end
							default: d.bre = 1'b0;
						endcase
					end
					OP_TEST_DIR: begin
						case (q.step)
							STEP_ONE: begin
								d.ea    = {DIRECT_PAGE, mem_rdata};
								d.pc    = pc_inc;
								d.bre   = 1'b1;
								d.baddr = {DIRECT_PAGE, mem_rdata};
							end
							STEP_TWO: d.cc = fl.flags_out; // RULE6
							default: begin
								d.st    = ST_FETCH;
								d.bre   = 1'b1;
								d.baddr = q.pc;
							end
						endcase
					end
					OP_ACC_STORE, OP_IDX_STORE: begin
						if (q.step == STEP_ONE) begin
							d.ea     = {DIRECT_PAGE, mem_rdata};
							d.pc     = pc_inc;
							d.bwe    = 1'b1;
							d.baddr  = {DIRECT_PAGE, mem_rdata};
							d.bwdata = (q.op == OP_ACC_STORE) ? q.a : q.x; // RULE9 RULE10
						end else begin
							d.cc    = fl.flags_out; // RULE9 RULE10
							d.st    = ST_FETCH;
							d.bre   = 1'b1;
							d.baddr = q.pc;
						end
					end
					OP_PAIR_STORE: begin
						case (q.step)
							STEP_ONE: begin
								d.ea     = {DIRECT_PAGE, mem_rdata};
								d.pc     = pc_inc;
								d.bwe    = 1'b1;
								d.baddr  = {DIRECT_PAGE, mem_rdata};
								d.bwdata = q.h; // RULE11
							end
							STEP_TWO: begin
								d.bwe    = 1'b1;
								d.baddr  = ea_inc; // RULE11
								d.bwdata = q.x;
							end
							default: begin
								d.cc    = fl.flags_out; // RULE11
								d.st    = ST_FETCH;
								d.bre   = 1'b1;
								d.baddr = q.pc;
							end
						endcase
					end
					OP_SP_TO_IDX: begin
						{d.h, d.x} = sp_inc; // RULE5
						d.st       = ST_FETCH;
						d.bre      = 1'b1;
						d.baddr    = q.pc;
					end
					OP_IDX_TO_SP: begin
						d.sp    = hx_dec; // RULE5
						d.st    = ST_FETCH;
						d.bre   = 1'b1;
						d.baddr = q.pc;
					end
					OP_WAIT: begin
						if (q.step == STEP_TWO) begin
							d.cc[FLG_I] = 1'b0; // RULE7
							d.st        = ST_WAIT;
						end
					end
					default: begin
						d.st    = ST_FETCH;
						d.bre   = 1'b1;
						d.baddr = q.pc;
					end
				endcase
			end
			ST_WAIT, ST_STOP: begin
				// halted: no bus traffic until an interrupt request
				if (wake_req) begin
					d.st    = ST_FETCH; // RULE7 RULE8
					d.bre   = 1'b1;
					d.baddr = q.pc;
				end
			end
			default: d = CORE_RESET;
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= CORE_RESET;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign mem_addr           = q.baddr;
	assign mem_wdata          = q.bwdata;
	assign mem_we             = q.bwe;
	assign mem_re             = q.bre;
	assign op_fetch           = (q.st == ST_FETCH);
	assign wait_halt          = (q.st == ST_WAIT);
	assign stop_halt          = (q.st == ST_STOP);
	assign acc                = q.a;
	assign index_hi           = q.h;
	assign index_lo           = q.x;
	assign stack_ptr          = q.sp;
	assign prog_cnt           = q.pc;
	assign condition_code_reg = q.cc;

	// checks on instruction effects
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_fetch(logic [7:0] code);
		q.st == ST_FETCH && mem_rdata == code;
	endsequence

	sequence s_byte_write(logic [7:0] val);
		q.bwe && q.bwdata == val;
	endsequence

	AST_TRAP_LEN: assert property ( // RULE1
		s_fetch(OP_SOFTWARE_TRAP) |=> (q.st != ST_FETCH)[*8] ##1 (q.st != ST_FETCH)[*2] ##1
		(q.st == ST_FETCH && q.cc[FLG_I] && q.sp == $past(q.sp, 11) - 16'h0005))
		else $error("trap length or state wrong");
	AST_ACC_TO_FLAGS: assert property ( // RULE2
		s_fetch(OP_ACC_TO_FLAGS) |=> q.st == ST_FETCH && q.cc == ($past(q.a) | FLAGS_ONES))
		else $error("flags not loaded from accumulator");
	AST_FLAGS_TO_ACC: assert property ( // RULE2
		s_fetch(OP_FLAGS_TO_ACC) |=> q.a == $past(q.cc) && $stable(q.cc))
		else $error("accumulator not loaded from flags");
	AST_ACC_TO_IDX: assert property ( // RULE3
		s_fetch(OP_ACC_TO_IDX) |=> q.st == ST_FETCH && q.x == $past(q.a) && $stable(q.cc))
		else $error("index low not loaded from accumulator");
	AST_IDX_TO_ACC: assert property ( // RULE4
		s_fetch(OP_IDX_TO_ACC) |=> q.st == ST_FETCH && q.a == $past(q.x) && $stable(q.cc))
		else $error("accumulator not loaded from index low");
	AST_SP_TO_IDX: assert property ( // RULE5
		s_fetch(OP_SP_TO_IDX) |=> q.st == ST_EXEC ##1
		(q.st == ST_FETCH && {q.h, q.x} == $past(q.sp, 2) + WORD_ONE))
		else $error("index pair not stack pointer plus one");
	AST_IDX_TO_SP: assert property ( // RULE5
		s_fetch(OP_IDX_TO_SP) |=> ##1 (q.st == ST_FETCH && q.sp == $past({q.h, q.x}, 2) - WORD_ONE))
		else $error("stack pointer not index pair minus one");
	AST_TEST_ACC: assert property ( // RULE6
		s_fetch(OP_TEST_ACC) |=> !q.cc[FLG_V] && q.cc[FLG_N] == $past(q.a[7])
		&& q.cc[FLG_Z] == ($past(q.a) == 8'h00) && q.cc[FLG_C] == $past(q.cc[FLG_C])
		&& q.cc[FLG_H] == $past(q.cc[FLG_H]))
		else $error("test flags wrong");
	AST_WAIT: assert property ( // RULE7
		s_fetch(OP_WAIT) |=> q.st == ST_EXEC ##2 (q.st == ST_WAIT && !q.cc[FLG_I]))
		else $error("wait did not halt with mask clear");
	AST_STOP: assert property ( // RULE8
		s_fetch(OP_STOP) |=> q.st == ST_STOP && !q.cc[FLG_I] && !q.bre)
		else $error("stop did not cease processing");
	AST_IDX_STORE: assert property ( // RULE9
		s_fetch(OP_IDX_STORE) |=> ##1 s_byte_write(q.x) ##1
		(q.st == ST_FETCH && !q.cc[FLG_V] && q.cc[FLG_Z] == (q.x == 8'h00)))
		else $error("index low store wrong");
	AST_ACC_STORE: assert property ( // RULE10
		s_fetch(OP_ACC_STORE) |=> ##1 s_byte_write(q.a) ##1
		(q.st == ST_FETCH && !q.cc[FLG_V] && q.cc[FLG_N] == q.a[7]))
		else $error("accumulator store wrong");
	AST_PAIR_STORE: assert property ( // RULE11
		s_fetch(OP_PAIR_STORE) |=> ##1 s_byte_write(q.h) ##1
		(s_byte_write(q.x) && q.baddr == $past(q.baddr) + WORD_ONE) ##1
		(q.st == ST_FETCH && q.cc[FLG_N] == q.h[7]))
		else $error("pair store wrong");
	AST_KEEP_FLAGS: assert property ( // RULE12
		s_fetch(OP_ACC_STORE) |=> ##2 (q.cc[FLG_C] == $past(q.cc[FLG_C], 3)
		&& q.cc[FLG_H] == $past(q.cc[FLG_H], 3) && q.cc[FLG_I] == $past(q.cc[FLG_I], 3)))
		else $error("unnamed flag changed");
endmodule : cpu_exec_core

// >>> test_cpu_store_transfer_test_ops.sv
// self-checking bench of the store, transfer, test, trap, wait and stop core
`timescale 1ns/10ps
module test_cpu_store_transfer_test_ops;
	import cpu_exec_pkg::*;

	typedef struct packed {
		logic [7:0]  op;
		logic [7:0]  opr;
		logic        two;
		logic [3:0]  cyc;
		logic [7:0]  a;
		logic [7:0]  x;
		logic [7:0]  h;
		logic [15:0] sp;
		logic [7:0]  cc;
		logic [7:0]  m;
	} row_s;

	localparam int N_ROWS = 17;

	logic        clk;
	logic        rstn;
	logic        wake_req;
	logic [7:0]  mem_rdata;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata;
	logic        mem_we;
	logic        mem_re;
	logic        op_fetch;
	logic        wait_halt;
	logic        stop_halt;
	logic [7:0]  acc;
	logic [7:0]  index_hi;
	logic [7:0]  index_lo;
	logic [15:0] stack_ptr;
	logic [15:0] prog_cnt;
	logic [7:0]  condition_code_reg;
	logic [7:0]  mem [0:65535];
	row_s        rows [N_ROWS];
	int          n_errors;
	int          checked;
	int          n;
	int          bad;
	logic [15:0] pc;

	cpu_exec_core dut (
		.clk                (clk),
		.rstn               (rstn),
		.mem_rdata          (mem_rdata),
		.wake_req           (wake_req),
		.mem_addr           (mem_addr),
		.mem_wdata          (mem_wdata),
		.mem_we             (mem_we),
		.mem_re             (mem_re),
		.op_fetch           (op_fetch),
		.wait_halt          (wait_halt),
		.stop_halt          (stop_halt),
		.acc                (acc),
		.index_hi           (index_hi),
		.index_lo           (index_lo),
		.stack_ptr          (stack_ptr),
		.prog_cnt           (prog_cnt),
		.condition_code_reg (condition_code_reg)
	);

	// clock generator, 10 ns period
	always #5 clk = ~clk;

	// memory answers at once; an idle bus shows a filler, not the last byte
	assign mem_rdata = (mem_re === 1'b1) ? mem[mem_addr] : 8'hA5;
	always @(posedge clk) begin
		if (mem_we === 1'b1) mem[mem_addr] <= mem_wdata;
	end

	// prints the counts and the verdict, then stops the run
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude

	// compares a seen value with the expected one
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
			n_errors++;
		end
	endtask : check

	// counts falling edges until op_fetch (0), wait_halt (1) or stop_halt (2) is high
	task automatic wait_for(input int sel, output int cnt);
		logic hit;
		cnt = 0;
		hit = 1'b0;
		while (!hit && cnt < 40) begin
			@(negedge clk);
			cnt++;
			hit = (sel == 0) ? (op_fetch === 1'b1) : (sel == 1) ? (wait_halt === 1'b1)
				: (stop_halt === 1'b1);
		end
		if (!hit) begin
			$display("MISMATCH wait bound expected 1 seen 0");
			n_errors++;
			conclude();
		end
	endtask : wait_for

	// counts cycles over twenty edges in which the core is not halted or fetches
	task automatic stalled(input int sel, output int cnt);
		cnt = 0;
		repeat (20) begin
			@(negedge clk);
			if (op_fetch !== 1'b0 || ((sel == 1) ? wait_halt : stop_halt) !== 1'b1) cnt++;
		end
	endtask : stalled

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		wake_req = 1'b0;
		n_errors = 0;
		checked = 0;
		// op, operand, two bytes, cycles, then a, x, h, sp, flags, memory byte
		rows = '{
			'{8'h4D, 8'h00, 1'b0, 4'h1, 8'h00, 8'h00, 8'h00, 16'h00FF, 8'h6A, 8'h00},
			'{8'h85, 8'h00, 1'b0, 4'h1, 8'h6A, 8'h00, 8'h00, 16'h00FF, 8'h6A, 8'h00},
			'{8'h3D, 8'h40, 1'b1, 4'h4, 8'h6A, 8'h00, 8'h00, 16'h00FF, 8'h6C, 8'h80},
			'{8'h85, 8'h00, 1'b0, 4'h1, 8'h6C, 8'h00, 8'h00, 16'h00FF, 8'h6C, 8'h00},
			'{8'h97, 8'h00, 1'b0, 4'h1, 8'h6C, 8'h6C, 8'h00, 16'h00FF, 8'h6C, 8'h00},
			'{8'h3D, 8'h41, 1'b1, 4'h4, 8'h6C, 8'h6C, 8'h00, 16'h00FF, 8'h6A, 8'h00},
			'{8'h85, 8'h00, 1'b0, 4'h1, 8'h6A, 8'h6C, 8'h00, 16'h00FF, 8'h6A, 8'h00},
			'{8'h9F, 8'h00, 1'b0, 4'h1, 8'h6C, 8'h6C, 8'h00, 16'h00FF, 8'h6A, 8'h00},
			'{8'h5D, 8'h00, 1'b0, 4'h1, 8'h6C, 8'h6C, 8'h00, 16'h00FF, 8'h68, 8'h00},
			'{8'h84, 8'h00, 1'b0, 4'h1, 8'h6C, 8'h6C, 8'h00, 16'h00FF, 8'h6C, 8'h00},
			'{8'h95, 8'h00, 1'b0, 4'h2, 8'h6C, 8'h00, 8'h01, 16'h00FF, 8'h6C, 8'h00},
			'{8'h97, 8'h00, 1'b0, 4'h1, 8'h6C, 8'h6C, 8'h01, 16'h00FF, 8'h6C, 8'h00},
			'{8'h94, 8'h00, 1'b0, 4'h2, 8'h6C, 8'h6C, 8'h01, 16'h016B, 8'h6C, 8'h00},
			'{8'h95, 8'h00, 1'b0, 4'h2, 8'h6C, 8'h6C, 8'h01, 16'h016B, 8'h6C, 8'h00},
			'{8'hB7, 8'h40, 1'b1, 4'h3, 8'h6C, 8'h6C, 8'h01, 16'h016B, 8'h68, 8'h6C},
			'{8'hBF, 8'h42, 1'b1, 4'h3, 8'h6C, 8'h6C, 8'h01, 16'h016B, 8'h68, 8'h6C},
			'{8'h35, 8'h44, 1'b1, 4'h4, 8'h6C, 8'h6C, 8'h01, 16'h016B, 8'h68, 8'h01}};
		// program image: rows from the reset address, then wait, trap and stop
		for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
		mem[16'h0040] = 8'h80;
		pc = RESET_PC;
		for (int i = 0; i < N_ROWS; i++) begin
			mem[pc] = rows[i].op;
			mem[pc + 16'h0001] = rows[i].opr;
			pc = pc + (rows[i].two ? 16'h0002 : 16'h0001);
		end
		mem[pc] = OP_WAIT;
		mem[pc + 16'h0001] = OP_SOFTWARE_TRAP;
		mem[pc + 16'h0002] = OP_STOP;
		mem[TRAP_VEC_HI] = 8'(pc + 16'h0002 >> 8);
		mem[TRAP_VEC_LO] = 8'(pc + 16'h0002);
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		// ordinary instructions, each checked at the next opcode fetch
		for (int i = 0; i < N_ROWS; i++) begin
			wait_for(0, n);
			check("cycles", 16'(n), 16'(rows[i].cyc));
			check("acc", acc, rows[i].a);
			check("index_lo", index_lo, rows[i].x);
			check("index_hi", index_hi, rows[i].h);
			check("stack_ptr", stack_ptr, rows[i].sp);
			check("flags", condition_code_reg, rows[i].cc);
			if (rows[i].two) check("mem", mem[{8'h00, rows[i].opr}], rows[i].m);
		end
		check("pair low byte", mem[16'h0045], 8'h6C);
		$display("test rows done");
		// wait: mask cleared, halts after three cycles, resumes on wake
		wait_for(1, n);
		check("wait cycles", 16'(n), 16'h0003);
		check("wait flags", condition_code_reg, 8'h60);
		stalled(1, bad);
		check("wait stall", 16'(bad), 16'h0000);
		wake_req = 1'b1;
		wait_for(0, n);
		wake_req = 1'b0;
		check("wake addr", mem_addr, pc + 16'h0001);
		$display("test wait done");
		// trap: eleven cycles, state pushed with the old mask, vector taken
		wait_for(0, n);
		check("trap cycles", 16'(n), 16'h000B);
		check("trap addr", mem_addr, pc + 16'h0002);
		check("trap pc", prog_cnt, pc + 16'h0002);
		check("push pcl", mem[16'h016B], 8'(pc + 16'h0002));
		check("push pch", mem[16'h016A], 8'(pc + 16'h0002 >> 8));
		check("push x", mem[16'h0169], 8'h6C);
		check("push a", mem[16'h0168], 8'h6C);
		check("push flags", mem[16'h0167], 8'h60);
		check("trap sp", stack_ptr, 16'h0166);
		check("trap flags", condition_code_reg, 8'h68);
		$display("test trap done");
		// stop: mask cleared, no fetch while halted, then a reset in mid-run
		wait_for(2, n);
		check("stop cycles", 16'(n), 16'h0001);
		check("stop flags", condition_code_reg, 8'h60);
		stalled(2, bad);
		check("stop stall", 16'(bad), 16'h0000);
		rstn = 1'b0;
		#1;
		check("rst addr", mem_addr, RESET_PC);
		check("rst sp", stack_ptr, RESET_SP);
		check("rst flags", condition_code_reg, FLAGS_RESET);
		check("rst halt", {stop_halt, wait_halt, mem_we, op_fetch}, 16'h0001);
		check("rst acc", {acc, index_lo}, 16'h0000);
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		wait_for(0, n);
		check("restart cycles", 16'(n), 16'h0001);
		check("restart flags", condition_code_reg, 8'h6A);
		$display("test reset done");
		conclude();
	end
endmodule : test_cpu_store_transfer_test_ops
